// ### core/scf_channel_cfg.sv
// Channel-pair enable and sync-header configuration with Avalon-MM slave
`timescale 1ns/10ps
`default_nettype none
`include "scf_regs.svh"
// Behaviour
// - Solo select runs channel A with half the converters; B, C, D off; first pair must stay set.
// - Outside solo select, second pair enable turns channels C and D on, clear turns them off.
// - Outside solo select, first pair enable turns channels A and B on, clear turns them off.
// - One pair off halves converters and uses ceiling of half the lanes.
// - Odd base lane count with a pair off pads tail bits on top lane.
// - First pair off moves C and D samples into A and B positions.
// - Sync-header select 0 gives CRC-12, 2 gives FEC; 1 and 3 reserved.
// - Sync-header select acts only while a 64b/66b format is chosen.
// - Sync word carries 32 bits per multi-block from sync headers.
// - No command channel; all command fields of sync word sent as zero.
module scf_channel_cfg #(
    parameter int BASE_LANES = 8,
    parameter int BASE_CONVERTERS = 4,
    parameter int SAMPLE_W = 12
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [`SCF_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic [1:0] o_avs_response,
    input wire logic i_block_strobe,
    input wire logic [SAMPLE_W-1:0] i_smp_a,
    input wire logic [SAMPLE_W-1:0] i_smp_b,
    input wire logic [SAMPLE_W-1:0] i_smp_c,
    input wire logic [SAMPLE_W-1:0] i_smp_d,
    output logic [3:0] o_chan_on,
    output logic [3:0] o_lanes_active,
    output logic [3:0] o_converters_active,
    output logic o_tail_pad,
    output logic [SAMPLE_W-1:0] o_slot0,
    output logic [SAMPLE_W-1:0] o_slot1,
    output logic [SAMPLE_W-1:0] o_slot2,
    output logic [SAMPLE_W-1:0] o_slot3,
    output logic o_link_enable,
    output logic o_cal_enable,
    output logic o_hdr_bit,
    output logic o_mb_start
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0] channel_pair_enable;
        logic [7:0] sh_sel;
        logic [7:0] link_ctrl;
        logic [31:0] rdata;
        logic wait_n;
        logic [1:0] resp;
        scf_pkg::scf_ch_mode_t mode;
        logic [3:0] chan_on;
        logic [3:0] lanes;
        logic [3:0] convs;
        logic tail;
        logic [4*SAMPLE_W-1:0] slots;
        logic [31:0] sw_word;
    } scf_state_t;

    scf_state_t st_q;
    scf_state_t st_d;
    logic [11:0] idx;
    logic hit;

    // Converts byte address to register index
    function automatic logic [11:0] reg_index(input logic [`SCF_ADDR_W-1:0] a);
        reg_index = a[`SCF_ADDR_W-1:2];
    endfunction : reg_index

    // Byte-lane merge on the low byte only
    function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
        wr_byte = be[0] ? wd[7:0] : old;
    endfunction : wr_byte

    // Sync-header kind from select field and link format
    function automatic scf_pkg::scf_sw_kind_t sw_kind(input logic [1:0] sel, input logic enc64);
        if (!enc64) begin
            sw_kind = scf_pkg::SCF_SW_NONE;
        end else if (sel == `SCF_SH_CRC12) begin
            sw_kind = scf_pkg::SCF_SW_CRC;
        end else if (sel == `SCF_SH_FEC) begin
            sw_kind = scf_pkg::SCF_SW_FEC;
        end else begin
            sw_kind = scf_pkg::SCF_SW_RSVD;
        end
    endfunction : sw_kind

    assign idx = reg_index(i_avs_address);
    assign hit = (idx == `SCF_IDX_CHANNEL_PAIR_ENABLE) || (idx == `SCF_IDX_SH_SEL) ||
                 (idx == `SCF_IDX_LINK_CTRL) || (idx == `SCF_IDX_STATUS) ||
                 (idx == `SCF_IDX_TX_WORD);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic first;
        logic second;
        logic solo;
        logic pair_off;
        logic [SAMPLE_W-1:0] sa;
        logic [SAMPLE_W-1:0] sb;
        logic [SAMPLE_W-1:0] sc;
        logic [SAMPLE_W-1:0] sd;
        scf_pkg::scf_sw_kind_t kind;
        st_d = st_q;
        pair_off = 1'b0;
        first = st_q.channel_pair_enable[`SCF_BIT_FIRST_PAIR];
        second = st_q.channel_pair_enable[`SCF_BIT_SECOND_PAIR];
        solo = st_q.channel_pair_enable[`SCF_BIT_SOLO];
        sa = i_smp_a;
        sb = i_smp_b;
        sc = i_smp_c;
        sd = i_smp_d;
        kind = sw_kind(st_q.sh_sel[1:0], st_q.link_ctrl[`SCF_BIT_ENC_64]);

        // Bus: one wait cycle, answer on the second edge
        st_d.wait_n = 1'b0;
        st_d.resp = 2'h0;
        if ((i_avs_read || i_avs_write) && !st_q.wait_n) begin
            st_d.wait_n = 1'b1;
            st_d.resp = hit ? 2'h0 : 2'h2;
            st_d.rdata = 32'h0000_0000;
            if (i_avs_read) begin
                unique case (idx)
                    `SCF_IDX_CHANNEL_PAIR_ENABLE: st_d.rdata = {24'h000000, st_q.channel_pair_enable};
                    `SCF_IDX_SH_SEL: st_d.rdata = {24'h000000, st_q.sh_sel};
                    `SCF_IDX_LINK_CTRL: st_d.rdata = {24'h000000, st_q.link_ctrl};
                    `SCF_IDX_STATUS: st_d.rdata = {16'h0000, st_q.convs, st_q.lanes,
                                                    st_q.chan_on, st_q.tail, 1'b0,
                                                    st_q.mode};
                    `SCF_IDX_TX_WORD: st_d.rdata = st_q.sw_word;
                    default: st_d.rdata = 32'h0000_0000;
                endcase
            end else begin
                // Ordering are the host's; writes are taken as given
                if (idx == `SCF_IDX_CHANNEL_PAIR_ENABLE) begin
                    st_d.channel_pair_enable = wr_byte(st_q.channel_pair_enable, i_avs_writedata, i_avs_byteenable);
                end
                if (idx == `SCF_IDX_SH_SEL) begin
                    st_d.sh_sel = wr_byte(st_q.sh_sel, i_avs_writedata, i_avs_byteenable);
                end
                if (idx == `SCF_IDX_LINK_CTRL) begin
                    st_d.link_ctrl = wr_byte(st_q.link_ctrl, i_avs_writedata,
                                             i_avs_byteenable);
                end
            end
        end

        // Channel mode decode
        if (solo) begin
            st_d.mode = scf_pkg::SCF_CH_SOLO;
            st_d.chan_on = 4'h1;
        end else begin
            st_d.chan_on = {second, second, first, first};
            if (first && second) begin
                st_d.mode = scf_pkg::SCF_CH_QUAD;
            end else if (first || second) begin
                st_d.mode = scf_pkg::SCF_CH_DUAL;
            end else begin
                st_d.mode = scf_pkg::SCF_CH_OFF;
            end
        end

        // Lane and converter scaling
        pair_off = (st_d.mode == scf_pkg::SCF_CH_DUAL) || (st_d.mode == scf_pkg::SCF_CH_SOLO);
        if (pair_off) begin
            st_d.lanes = 4'((BASE_LANES + 1) / 2);
            st_d.convs = 4'(BASE_CONVERTERS / 2);
            st_d.tail = (BASE_LANES % 2) != 0;
        end else begin
            st_d.lanes = 4'(BASE_LANES);
            st_d.convs = 4'(BASE_CONVERTERS);
            st_d.tail = 1'b0;
        end

        // Sample placement
        if (!solo && !first) begin
            st_d.slots = {{2*SAMPLE_W{1'b0}}, sd, sc};
        end else begin
            st_d.slots = {sd & {SAMPLE_W{st_d.chan_on[3]}}, sc & {SAMPLE_W{st_d.chan_on[2]}},
                          sb & {SAMPLE_W{st_d.chan_on[1]}}, sa};
        end

        // Sync word content; command fields stay zero
        unique case (kind)
            scf_pkg::SCF_SW_CRC: st_d.sw_word = {16'h0000, 4'h0, 12'hFFF} & 32'h0000_0FFF;
            scf_pkg::SCF_SW_FEC: st_d.sw_word = 32'hFFFF_FFFF >> 6;
            scf_pkg::SCF_SW_RSVD: st_d.sw_word = 32'h0000_0000;
            scf_pkg::SCF_SW_NONE: st_d.sw_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            st_q <= '0;
            st_q.channel_pair_enable <= `SCF_RST_CHANNEL_PAIR_ENABLE;
            st_q.sh_sel <= `SCF_RST_SH_SEL;
            st_q.link_ctrl <= `SCF_RST_LINK_CTRL;
            st_q.chan_on <= 4'hF;
            st_q.lanes <= 4'(BASE_LANES);
            st_q.convs <= 4'(BASE_CONVERTERS);
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Sync-word serialiser
    // ****************************************************************
    logic sw_strobe;
    assign sw_strobe = i_block_strobe && st_q.link_ctrl[`SCF_BIT_ENC_64] &&
                       st_q.link_ctrl[`SCF_BIT_LINK_EN];

    scf_sync_word #(
        .BLOCKS(`SCF_SYNC_WORD_BITS)
    ) u_sync_word (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_block_strobe(sw_strobe),
        .i_word(st_q.sw_word),
        .o_hdr_bit(o_hdr_bit),
        .o_mb_start(o_mb_start)
    );

    assign o_avs_readdata = st_q.rdata;
    assign o_avs_waitrequest = !st_q.wait_n;
    assign o_avs_response = st_q.resp;
    assign o_chan_on = st_q.chan_on;
    assign o_lanes_active = st_q.lanes;
    assign o_converters_active = st_q.convs;
    assign o_tail_pad = st_q.tail;
    assign o_slot0 = st_q.slots[SAMPLE_W-1:0];
    assign o_slot1 = st_q.slots[2*SAMPLE_W-1:SAMPLE_W];
    assign o_slot2 = st_q.slots[3*SAMPLE_W-1:2*SAMPLE_W];
    assign o_slot3 = st_q.slots[4*SAMPLE_W-1:3*SAMPLE_W];
    assign o_link_enable = st_q.link_ctrl[`SCF_BIT_LINK_EN];
    assign o_cal_enable = st_q.link_ctrl[`SCF_BIT_CAL_EN];
endmodule : scf_channel_cfg
`default_nettype wire

// ### core/scf_pkg.sv
// Types shared by the channel/sync-word block
package scf_pkg;
    typedef enum logic [1:0] {
        SCF_CH_QUAD,
        SCF_CH_DUAL,
        SCF_CH_SOLO,
        SCF_CH_OFF
    } scf_ch_mode_t;

    typedef enum logic [1:0] {
        SCF_SW_CRC,
        SCF_SW_FEC,
        SCF_SW_RSVD,
        SCF_SW_NONE
    } scf_sw_kind_t;
endpackage : scf_pkg

// ### core/scf_regs.svh
// Register offsets, field positions, reset values and constants for the channel/sync-word block
`ifndef SCF_REGS_SVH
`define SCF_REGS_SVH

`define SCF_IDX_CHANNEL_PAIR_ENABLE 12'h209
`define SCF_IDX_SH_SEL 12'h20F
`define SCF_IDX_LINK_CTRL 12'h300
`define SCF_IDX_STATUS 12'h301
`define SCF_IDX_TX_WORD 12'h302

`define SCF_ADDR_W 14
`define SCF_BIT_FIRST_PAIR 0
`define SCF_BIT_SECOND_PAIR 1
`define SCF_BIT_SOLO 2
`define SCF_BIT_LINK_EN 0
`define SCF_BIT_CAL_EN 1
`define SCF_BIT_ENC_64 2

`define SCF_RST_CHANNEL_PAIR_ENABLE 8'h03
`define SCF_RST_SH_SEL 8'h00
`define SCF_RST_LINK_CTRL 8'h00

`define SCF_SH_CRC12 2'h0
`define SCF_SH_FEC 2'h2

`define SCF_SYNC_WORD_BITS 32
`define SCF_MB_BLOCKS 32

`endif

// ### core/scf_sync_word.sv
// Sync-word serialiser: one sync-header bit per 64b/66b block, 32 per multi-block
`timescale 1ns/10ps
`default_nettype none
`include "scf_regs.svh"
module scf_sync_word #(
    parameter int BLOCKS = `SCF_MB_BLOCKS
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_block_strobe,
    input wire logic [31:0] i_word,
    output logic o_hdr_bit,
    output logic o_mb_start
);
    typedef struct packed {
        logic [31:0] shift;
        logic [4:0] cnt;
        logic hdr;
        logic start;
    } scf_sw_state_t;

    scf_sw_state_t st_q;
    scf_sw_state_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.start = 1'b0;
        if (i_block_strobe) begin
            if (st_q.cnt == 5'h00) begin
                st_d.shift = {i_word[30:0], 1'b0};
                st_d.hdr = i_word[31];
                st_d.start = 1'b1;
            end else begin
                st_d.shift = {st_q.shift[30:0], 1'b0};
                st_d.hdr = st_q.shift[31];
            end
            st_d.cnt = (st_q.cnt == 5'(BLOCKS - 1)) ? 5'h00 : 5'(st_q.cnt + 5'h01);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_hdr_bit = st_q.hdr;
    assign o_mb_start = st_q.start;
endmodule : scf_sync_word
`default_nettype wire

// ### tb/scf_channel_cfg_monitor.sv
// Port checker for the channel/sync-word block
`timescale 1ns/10ps
`default_nettype none
`include "scf_regs.svh"
module scf_channel_cfg_monitor #(
    parameter int BASE_LANES = 8,
    parameter int BASE_CONVERTERS = 4,
    parameter int SAMPLE_W = 12
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [`SCF_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [1:0] o_avs_response,
    input wire logic [SAMPLE_W-1:0] i_smp_c,
    input wire logic [SAMPLE_W-1:0] i_smp_d,
    input wire logic [3:0] o_chan_on,
    input wire logic [3:0] o_lanes_active,
    input wire logic [3:0] o_converters_active,
    input wire logic o_tail_pad,
    input wire logic [SAMPLE_W-1:0] o_slot0,
    input wire logic [SAMPLE_W-1:0] o_slot1
);
    logic wr_ch;
    logic [2:0] wd;
    assign wd = i_avs_writedata[2:0];
    assign wr_ch = i_avs_write && !o_avs_waitrequest && i_avs_address[13:2] == `SCF_IDX_CHANNEL_PAIR_ENABLE
        && i_avs_byteenable[0];
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    chk_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("answer late");
    chk_unmapped_err: assert property (i_avs_read && o_avs_waitrequest
        && !(i_avs_address[13:2] inside {12'h209, 12'h20F, 12'h300, 12'h301, 12'h302})
        |=> o_avs_response == 2'h2 && o_avs_readdata == 32'h0) else $error("no error");
    chk_pair_ab: assert property (wr_ch && !wd[0] |=> o_chan_on[1:0] == 2'h0)
        else $error("first pair still on");
    chk_pair_cd: assert property (wr_ch && !wd[2]
        |=> o_chan_on[3:2] == {2{$past(i_avs_writedata[1])}}) else $error("second pair wrong");
    chk_solo_mode: assert property (wr_ch && wd == 3'h5
        |=> o_chan_on == 4'h1 && o_converters_active == BASE_CONVERTERS / 2)
        else $error("solo wrong");
    chk_lane_scale: assert property (wr_ch && (wd == 3'h1 || wd == 3'h2)
        |=> o_lanes_active == (BASE_LANES + 1) / 2 && o_converters_active == BASE_CONVERTERS / 2)
        else $error("scaling wrong");
    chk_tail_pad: assert property (wr_ch && (wd == 3'h1 || wd == 3'h2)
        |=> o_tail_pad == BASE_LANES % 2) else $error("tail pad wrong");
    chk_slot_move: assert property ((!o_chan_on[0] && o_chan_on[2]) [*2]
        |-> o_slot0 == $past(i_smp_c) && o_slot1 == $past(i_smp_d)) else $error("slots wrong");
endmodule : scf_channel_cfg_monitor
bind scf_channel_cfg scf_channel_cfg_monitor #(.BASE_LANES(BASE_LANES),
    .BASE_CONVERTERS(BASE_CONVERTERS), .SAMPLE_W(SAMPLE_W)) mon_u (.i_core_clk, .i_rst_b,
    .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
    .o_avs_readdata, .o_avs_waitrequest, .o_avs_response, .i_smp_c, .i_smp_d, .o_chan_on,
    .o_lanes_active, .o_converters_active, .o_tail_pad, .o_slot0, .o_slot1);
`default_nettype wire

// ### tb/scf_channel_cfg_tb.sv
// Self-checking bench for the channel/sync-word block
`timescale 1ns/10ps
`default_nettype none
`include "scf_regs.svh"
module scf_channel_cfg_tb;
    typedef struct packed {
        logic [7:0] ch;
        logic [3:0] on, ln, cv;
        logic tl;
        logic [1:0] md;
    } scf_row_t;
    typedef struct packed {
        logic [7:0] ctl, sel;
        logic [31:0] w;
    } scf_sw_t;
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [13:0] i_avs_address = 14'h0000;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h00000000;
    logic [3:0] i_avs_byteenable = 4'h1;
    logic i_block_strobe = 1'b0;
    logic [11:0] i_smp_a = 12'hA01, i_smp_b = 12'hB02, i_smp_c = 12'hC03, i_smp_d = 12'hD04;
    logic [31:0] o_avs_readdata, rx_word, q;
    logic [1:0] o_avs_response, r;
    logic o_avs_waitrequest, o_tail_pad, o_link_enable, o_cal_enable, o_hdr_bit, o_mb_start;
    logic rx_vld;
    logic [3:0] o_chan_on, o_lanes_active, o_converters_active;
    logic [11:0] o_slot0, o_slot1, o_slot2, o_slot3;
    int checked = 0, miscompares = 0, cycles = 0;
    scf_row_t rows [4] = '{'{8'h03, 4'hF, 4'h7, 4'h4, 1'b0, 2'h0},
        '{8'h02, 4'hC, 4'h4, 4'h2, 1'b1, 2'h1}, '{8'h01, 4'h3, 4'h4, 4'h2, 1'b1, 2'h1},
        '{8'h05, 4'h1, 4'h4, 4'h2, 1'b1, 2'h2}};
    scf_sw_t sws [5] = '{'{8'h05, 8'h00, 32'h00000FFF}, '{8'h05, 8'h01, 32'h00000000},
        '{8'h05, 8'h02, 32'h03FFFFFF}, '{8'h05, 8'h03, 32'h00000000},
        '{8'h01, 8'h02, 32'h00000000}};
    scf_channel_cfg #(.BASE_LANES(7), .BASE_CONVERTERS(4), .SAMPLE_W(12)) dut_u (.i_core_clk,
        .i_rst_b, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
        .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_avs_response,
        .i_block_strobe, .i_smp_a, .i_smp_b, .i_smp_c, .i_smp_d, .o_chan_on, .o_lanes_active,
        .o_converters_active, .o_tail_pad, .o_slot0, .o_slot1, .o_slot2, .o_slot3,
        .o_link_enable, .o_cal_enable, .o_hdr_bit, .o_mb_start);
    scf_rx_model rx_u (.i_core_clk, .i_rst_b, .i_strobe(i_block_strobe && o_link_enable),
        .i_hdr_bit(o_hdr_bit),
        .i_mb_start(o_mb_start), .o_word(rx_word), .o_word_vld(rx_vld));
    always #10 i_core_clk = !i_core_clk;
    always @(posedge i_core_clk) begin
        i_block_strobe <= !i_block_strobe;
        i_smp_c <= i_smp_c + 12'h001;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d,
        output logic [31:0] rq, output logic [1:0] rr);
        @(posedge i_core_clk);
        i_avs_address <= {idx, 2'h0};
        i_avs_read <= !w;
        i_avs_write <= w;
        i_avs_writedata <= {24'h000000, d};
        do @(posedge i_core_clk); while (o_avs_waitrequest !== 1'b0);
        rq = o_avs_readdata;
        rr = o_avs_response;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask : bus
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic rx_wait(input logic [31:0] e);
        repeat (2) begin
            @(posedge i_core_clk);
            while (rx_vld !== 1'b1) @(posedge i_core_clk);
        end
        chk("rx word", e, rx_word);
    endtask : rx_wait
    task automatic end_of_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    // ****************
    // Tests
    // ****************
    initial begin
        repeat (3) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        foreach (rows[i]) begin
            bus(1'b1, `SCF_IDX_CHANNEL_PAIR_ENABLE, rows[i].ch, q, r);
            bus(1'b0, `SCF_IDX_CHANNEL_PAIR_ENABLE, 8'h00, q, r);
            chk("channel_pair_enable", 32'(rows[i].ch), q);
            bus(1'b0, `SCF_IDX_STATUS, 8'h00, q, r);
            chk("mode", 32'(rows[i].md), 32'(q[1:0]));
            chk("chan_on", 32'(rows[i].on), 32'(o_chan_on));
            chk("lanes", 32'(rows[i].ln), 32'(o_lanes_active));
            chk("converters", 32'(rows[i].cv), 32'(o_converters_active));
            chk("tail", 32'(rows[i].tl), 32'(o_tail_pad));
            chk("slot1", rows[i].ch[0] ? (rows[i].on[1] ? 32'h00000B02 : 32'h00000000) : 32'h00000D04, 32'(o_slot1));
            chk("slot3", (rows[i].ch[0] && rows[i].on[3]) ? 32'h00000D04 : 32'h00000000, 32'(o_slot3));
        end
        $display("test channels done");
        foreach (sws[i]) begin
            bus(1'b1, `SCF_IDX_LINK_CTRL, 8'h00, q, r);
            bus(1'b1, `SCF_IDX_SH_SEL, sws[i].sel, q, r);
            bus(1'b1, `SCF_IDX_LINK_CTRL, sws[i].ctl, q, r);
            bus(1'b0, `SCF_IDX_TX_WORD, 8'h00, q, r);
            chk("sync word", sws[i].w, q);
            if (sws[i].ctl == 8'h05) rx_wait(sws[i].w);
        end
        $display("test sync word done");
        i_rst_b <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        bus(1'b0, `SCF_IDX_CHANNEL_PAIR_ENABLE, 8'h00, q, r);
        chk("channel_pair_enable reset", 32'h00000003, q);
        bus(1'b0, `SCF_IDX_SH_SEL, 8'h00, q, r);
        chk("sh_sel reset", 32'h00000000, q);
        chk("link_en reset", 32'h00000000, 32'(o_link_enable));
        bus(1'b1, `SCF_IDX_LINK_CTRL, 8'h02, q, r);
        chk("cal_en", 32'h00000001, 32'(o_cal_enable));
        bus(1'b0, 12'h100, 8'h00, q, r);
        chk("unmapped response", 32'h00000002, 32'(r));
        $display("test reset done");
        end_of_test();
    end
endmodule : scf_channel_cfg_tb
`default_nettype wire

// ### tb/scf_rx_model.sv
// Link receiver model: rebuilds each sync word from header bits
`timescale 1ns/10ps
`default_nettype none
module scf_rx_model (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_strobe,
    input wire logic i_hdr_bit,
    input wire logic i_mb_start,
    output logic [31:0] o_word,
    output logic o_word_vld
);
    logic stb_q;
    logic [31:0] sh_q;
    int n_q;
    always_ff @(posedge i_core_clk) begin
        stb_q <= i_strobe;
        o_word_vld <= 1'b0;
        if (!i_rst_b) begin
            n_q <= 64;
        end else if (stb_q) begin
            sh_q <= {sh_q[30:0], i_hdr_bit};
            n_q <= i_mb_start ? 1 : n_q + 1;
            if (n_q == 31 && !i_mb_start) begin
                o_word <= {sh_q[30:0], i_hdr_bit};
                o_word_vld <= 1'b1;
            end
        end
    end
endmodule : scf_rx_model
`default_nettype wire
